// file: design/mseq_pkg.sv
/*
 * shared constants and carriers of the microsequencer clock and trace block.
 * assumes a 100 MHz aclk and an AXI4-Lite master with a 4-bit byte address.
 */
package mseq_pkg;
   localparam int UADDR_W  = 9;  // microaddress width
   localparam int REG_EN_W = 8;  // register clock enable gates
   localparam int CTL_W    = 8;  // remaining control bits passed through

   // cycle length field of the microword
   typedef enum logic [1:0] {
      cyc_unused                = 2'h0,
      single_first_pulse_cycle  = 2'h1,
      single_second_pulse_cycle = 2'h2,
      double_pulse_cycle        = 2'h3
   } cyc_len_e;

   typedef struct packed {
      logic [UADDR_W-1:0]  next_field;
      cyc_len_e            clk_len;
      logic                microword_clock_halt;
      logic                bus_wait;
      logic [REG_EN_W-1:0] reg_en;
      logic [CTL_W-1:0]    ctl;
   } microword_s;

   typedef struct packed {
      logic first_pulse;
      logic second_pulse;
      logic third_pulse;
      logic last;
   } pulse_s;

   // register map, byte addresses
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_ADDR   = 4'h8;
   // field positions
   localparam int CTRL_RESUME_BIT = 0;
   localparam int CTRL_STOP_BIT   = 1;
   localparam int STAT_IDLE_BIT   = 0;
   localparam int STAT_MATCH_BIT  = 1;
   localparam int STAT_HALT_BIT   = 2;
   localparam int ADDR_PAST_LSB   = 0;
   localparam int ADDR_NEXT_LSB   = 16;
   // reset values
   localparam logic             IDLE_RST  = 1'b1;
   localparam logic [UADDR_W-1:0] UADDR_RST = 9'h000;
   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/pin_sync.sv
/*
 * three-flop synchroniser for slow pins; a bit changes once stages two
 * and three agree. assumes the pins are quasi-static or level requests.
 */
`timescale 1ns/1ps
module pin_sync
   import mseq_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_s;

   sync_s st_r;
   sync_s st_nxt;

   // s1 is only read by s2; agreement of s2 and s3 filters a late settle
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q  = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.q);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.q;
endmodule

// file: design/pulse_gen.sv
/*
 * clock pulse generator: one trigger gives one machine-state cycle of
 * one or two pulses. assumes trigger is a one-cycle pulse from clock control.
 */
`timescale 1ns/1ps
module pulse_gen
   import mseq_pkg::*;
(
   input  wire logic     aclk,
   input  wire logic     aresetn,
   input  wire logic     trigger,
   input  cyc_len_e      len,
   output pulse_s        pulses,
   output logic          busy
);
   typedef enum logic [3:0] {
      PG_WAIT = 4'b0001,
      PG_P1   = 4'b0010,
      PG_P2   = 4'b0100,
      PG_P3   = 4'b1000
   } pg_state_e;

   typedef struct packed {
      pg_state_e state;
      cyc_len_e  len;
      pulse_s    pls;
   } pg_s;

   pg_s st_r;
   pg_s st_nxt;

   // a trigger is taken only in wait, so a stray one cannot split a cycle
   always_comb begin
      st_nxt     = st_r;
      st_nxt.pls = '0;
      unique case (st_r.state)
         PG_WAIT: begin
            if (trigger) begin
               st_nxt.len = len;
               if (len == single_second_pulse_cycle || len == double_pulse_cycle) begin
                  st_nxt.state            = PG_P2;
                  st_nxt.pls.second_pulse = 1'b1;  // R06
                  st_nxt.pls.last         = (len != double_pulse_cycle);
               end else begin
                  st_nxt.state           = PG_P1;  // unused code runs as short
                  st_nxt.pls.first_pulse = 1'b1;  // R06
                  st_nxt.pls.last        = 1'b1;
               end
            end
         end
         PG_P2: begin
            if (st_r.len == double_pulse_cycle) begin
               st_nxt.state           = PG_P3;  // R08
               st_nxt.pls.third_pulse = 1'b1;
               st_nxt.pls.last        = 1'b1;
            end else begin
               st_nxt.state = PG_WAIT;
            end
         end
         PG_P1, PG_P3: begin
            st_nxt.state = PG_WAIT;
         end
         default: begin
            st_nxt.state = PG_WAIT;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r       <= '0;
         st_r.state <= PG_WAIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulses = st_r.pls;
   assign busy   = (st_r.state != PG_WAIT);
endmodule

// file: design/mseq_clock_trace.sv
/*
 * microsequencer clock control, microword and microaddress registers,
 * past-address trace, switch match strobe/halt, and an AXI4-Lite slave.
 * assumes rom_word is the ROM data at next_microaddress_reg, settled by
 * the last pulse of a state; branch and force inputs come from aclk logic.
 */
// Overview of operation
// [R01] past address loads next address whenever the microword loads
// [R02] past address drives the console display and is readable over the bus
// [R03] match asserts when next address bits 8..0 equal the switch bits
// [R04] enabled match stops the clock with the matched microword loaded
// [R05] enabled match gates the state's final pulse out as a scope strobe
// [R06] cycles: short first pulse, middle second pulse, long second then third
// [R07] cycle length comes from the loaded microword's length field
// [R08] long cycle gives read then write back within one state
// [R09] trigger starts a cycle on resume, restart or maintenance request
// [R10] resume trigger withheld while microword halt bit is set and clock is idle
// [R11] restart or maintenance clears idle and retriggers the generator
// [R12] each register clock pulse passes only under its microword enable bit
// [R13] bus wait stops the clock until the bus side requests resume
// [R14] microword loads on the last pulse of the preceding state
// [R15] forced address overrides the next address register directly
// [R16] halt and strobe on match each need their own console enable
`timescale 1ns/1ps
module mseq_clock_trace
   import mseq_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [3:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [3:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  microword_s               rom_word,
   input  wire logic [UADDR_W-1:0]  branch_mod,
   input  wire logic                force_valid,
   input  wire logic [UADDR_W-1:0]  force_addr,
   input  wire logic                async_restart,
   input  wire logic                maint_control,
   input  wire logic                clock_resume_req,
   input  wire logic [UADDR_W-1:0]  console_switch_value,
   input  wire logic                halt_match_en,
   input  wire logic                strobe_match_en,
   output microword_s               microword,
   output logic [UADDR_W-1:0]       next_microaddress_reg,
   output logic [UADDR_W-1:0]       past_microaddress_reg,
   output logic                     match,
   output logic                     scope_strobe,
   output pulse_s                   pulses,
   output logic [REG_EN_W-1:0]      reg_clk,
   output logic                     clock_idle
);
   localparam int SYNC_W = UADDR_W + 5;

   typedef struct packed {
      microword_s          mw;
      logic [UADDR_W-1:0]  next;
      logic [UADDR_W-1:0]  past;
      logic                match;
      logic                strobe;
      pulse_s              pls;
      logic [REG_EN_W-1:0] reg_clk;
      logic                idle;
      logic                trigger;
      logic                restart_q;
      logic                maint_q;
      logic                resume_q;
      logic                ctrl_resume;
      logic                ctrl_stop;
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
      logic                aw_have;
      logic                w_have;
      logic [3:0]          awaddr;
      logic [31:0]         wdata;
      logic [3:0]          wstrb;
   } state_s;

   state_s               st_r;
   state_s               st_nxt;
   logic [SYNC_W-1:0]    sync_level;
   logic [UADDR_W-1:0]   sw_sync;
   logic                 restart_sync;
   logic                 maint_sync;
   logic                 resume_sync;
   logic                 halt_en_sync;
   logic                 strobe_en_sync;
   pulse_s               pg_pls;
   logic                 pg_busy;
   logic                 match_now;
   logic                 restart_edge;
   logic                 maint_edge;
   logic                 resume_any;
   logic                 stop_now;
   logic                 any_pulse;

   // console and restart pins cross into aclk here
   pin_sync #(
      .W (SYNC_W)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     ({console_switch_value, async_restart, maint_control, clock_resume_req,
                 halt_match_en, strobe_match_en}),
      .level   (sync_level)
   );

   assign {sw_sync, restart_sync, maint_sync, resume_sync, halt_en_sync, strobe_en_sync} = sync_level;

   // pulse generator, triggered by the clock control flop
   pulse_gen u_pg (
      .aclk    (aclk),
      .aresetn (aresetn),
      .trigger (st_r.trigger),
      .len     (st_r.mw.clk_len),  // R07
      .pulses  (pg_pls),
      .busy    (pg_busy)
   );

   // decoded events for the clock control
   assign match_now    = (st_r.next == sw_sync);  // R03
   assign restart_edge = restart_sync & ~st_r.restart_q;
   assign maint_edge   = maint_sync & ~st_r.maint_q;
   assign resume_any   = (resume_sync & ~st_r.resume_q) | st_r.ctrl_resume;
   assign any_pulse    = pg_pls.first_pulse | pg_pls.second_pulse | pg_pls.third_pulse;
   // the incoming word, an enabled switch match or the stop bit decide whether the clock keeps running
   assign stop_now     = rom_word.microword_clock_halt | rom_word.bus_wait  // R13
                       | (match_now & halt_en_sync) | st_r.ctrl_stop;  // R04 R16

   // sequencer, trace and bus next state
   always_comb begin
      st_nxt             = st_r;
      st_nxt.restart_q   = restart_sync;
      st_nxt.maint_q     = maint_sync;
      st_nxt.resume_q    = resume_sync;
      st_nxt.trigger     = 1'b0;
      st_nxt.ctrl_resume = 1'b0;
      st_nxt.match       = match_now;  // R03
      st_nxt.pls         = pg_pls;
      // enable gates: a register sees a pulse only with its bit set
      st_nxt.reg_clk     = {REG_EN_W{any_pulse}} & st_r.mw.reg_en;  // R12
      // strobe is the state's final pulse, one state ahead of the match word
      st_nxt.strobe      = pg_pls.last & match_now & strobe_en_sync;  // R05 R16

      // microword, next and past address load together on the last pulse
      if (pg_pls.last) begin
         st_nxt.mw   = rom_word;  // R14
         st_nxt.past = st_r.next;  // R01
         st_nxt.next = rom_word.next_field | branch_mod;
         if (stop_now) begin
            st_nxt.idle = 1'b1;  // R04 R13
         end else begin
            st_nxt.trigger = 1'b1;
         end
      end else if (st_r.idle && !pg_busy) begin
         // restart and maintenance override a halt bit, resume does not
         if (restart_edge || maint_edge) begin
            st_nxt.idle    = 1'b0;  // R11
            st_nxt.trigger = 1'b1;  // R09
         end else if (resume_any && !st_r.mw.microword_clock_halt) begin  // R10
            st_nxt.idle    = 1'b0;
            st_nxt.trigger = 1'b1;  // R09 R13
         end
      end
      // a jammed address wins over the clocked path, even on the last pulse
      if (force_valid) begin
         st_nxt.next = force_addr;  // R15
      end

      // write side: address and data are taken in either order
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_have = 1'b1;
         st_nxt.awaddr  = s_axi_awaddr;
         st_nxt.awready = 1'b0;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_have = 1'b1;
         st_nxt.wdata  = s_axi_wdata;
         st_nxt.wstrb  = s_axi_wstrb;
         st_nxt.wready = 1'b0;
      end
      if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = RESP_OKAY;
         unique case (st_r.awaddr & 4'hC)
            OFS_CTRL: begin
               if (st_r.wstrb[0]) begin
                  st_nxt.ctrl_resume = st_r.wdata[CTRL_RESUME_BIT];
                  st_nxt.ctrl_stop   = st_r.wdata[CTRL_STOP_BIT];
               end
            end
            OFS_STATUS, OFS_ADDR: begin
               st_nxt.bresp = RESP_OKAY;  // read-only, write ignored
            end
            default: begin
               st_nxt.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid  = 1'b0;
         st_nxt.awready = 1'b1;
         st_nxt.wready  = 1'b1;
      end

      // read side: one read at a time, answered the cycle after the address
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.arready = 1'b0;
         st_nxt.rvalid  = 1'b1;
         st_nxt.rresp   = RESP_OKAY;
         st_nxt.rdata   = 32'h0000_0000;
         unique case (s_axi_araddr & 4'hC)
            OFS_CTRL: begin
               st_nxt.rdata[CTRL_STOP_BIT] = st_r.ctrl_stop;
            end
            OFS_STATUS: begin
               st_nxt.rdata[STAT_IDLE_BIT]  = st_r.idle;
               st_nxt.rdata[STAT_MATCH_BIT] = st_r.match;
               st_nxt.rdata[STAT_HALT_BIT]  = st_r.mw.microword_clock_halt;
            end
            OFS_ADDR: begin
               st_nxt.rdata[ADDR_PAST_LSB +: UADDR_W] = st_r.past;  // R02
               st_nxt.rdata[ADDR_NEXT_LSB +: UADDR_W] = st_r.next;
            end
            default: begin
               st_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid  = 1'b0;
         st_nxt.arready = 1'b1;
      end
   end

   // the clock stays idle after reset until a start request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r         <= '0;
         st_r.idle    <= IDLE_RST;
         st_r.next    <= UADDR_RST;
         st_r.past    <= UADDR_RST;
         st_r.awready <= 1'b1;
         st_r.wready  <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign s_axi_awready         = st_r.awready;
   assign s_axi_wready          = st_r.wready;
   assign s_axi_bresp           = st_r.bresp;
   assign s_axi_bvalid          = st_r.bvalid;
   assign s_axi_arready         = st_r.arready;
   assign s_axi_rdata           = st_r.rdata;
   assign s_axi_rresp           = st_r.rresp;
   assign s_axi_rvalid          = st_r.rvalid;
   assign microword             = st_r.mw;
   assign next_microaddress_reg = st_r.next;
   assign past_microaddress_reg = st_r.past;  // R02
   assign match                 = st_r.match;
   assign scope_strobe          = st_r.strobe;
   assign pulses                = st_r.pls;
   assign reg_clk               = st_r.reg_clk;
   assign clock_idle            = st_r.idle;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_past_follow: assert property (pg_pls.last |=> st_r.past == $past(st_r.next))  // R01
      else $error("past address did not follow next address");
   // the release edge still loads reset values, so only compare after a clean cycle
   a_match_value: assert property (aresetn |=> match == $past(st_r.next == sw_sync))  // R03
      else $error("match flag wrong");
   a_match_halt: assert property (pg_pls.last && match_now && halt_en_sync |=> clock_idle && !st_r.trigger)  // R04
      else $error("enabled match did not stop the clock");
   a_strobe_gate: assert property (pg_pls.last && match_now |=> scope_strobe == $past(strobe_en_sync))  // R05
      else $error("strobe not gated by match and enable");
   a_strobe_only: assert property (scope_strobe |-> $past(pg_pls.last))  // R05
      else $error("strobe outside a final pulse");
   a_short_cycle: assert property (st_r.trigger && !pg_busy && st_r.mw.clk_len == single_first_pulse_cycle
      |=> pg_pls.first_pulse && pg_pls.last ##1 !any_pulse)  // R06
      else $error("short cycle pulse wrong");
   a_long_cycle: assert property (st_r.trigger && !pg_busy && st_r.mw.clk_len == double_pulse_cycle
      |=> pg_pls.second_pulse && !pg_pls.last ##1 pg_pls.third_pulse && pg_pls.last)  // R08
      else $error("long cycle pulse pair wrong");
   a_withhold: assert property (clock_idle && st_r.mw.microword_clock_halt && !restart_edge && !maint_edge
      && !pg_pls.last |=> !st_r.trigger)  // R10
      else $error("trigger not withheld under halt bit");
   a_restart: assert property (clock_idle && !pg_busy && !pg_pls.last && restart_edge
      |=> !clock_idle && st_r.trigger ##1 any_pulse)  // R11
      else $error("restart did not retrigger the generator");
   a_gate_pass: assert property (reg_clk != '0 |-> $past(any_pulse) && (reg_clk & ~$past(st_r.mw.reg_en)) == '0)  // R12
      else $error("register pulse without enable");
   a_bus_wait: assert property (pg_pls.last && rom_word.bus_wait |=> clock_idle ##1 !pg_busy)  // R13
      else $error("bus wait did not stop the clock");
   a_load_last: assert property (pg_pls.last |=> microword == $past(rom_word))  // R14
      else $error("microword not loaded on last pulse");
   a_force_addr: assert property (force_valid |=> next_microaddress_reg == $past(force_addr))  // R15
      else $error("forced address not taken");

   c_long_cycle: cover property (pg_pls.second_pulse ##1 pg_pls.third_pulse);
   c_match_halt: cover property (pg_pls.last && match_now && halt_en_sync ##1 clock_idle);
   c_restart:    cover property (restart_edge && clock_idle ##1 st_r.trigger);
   c_strobe:     cover property (scope_strobe);
endmodule

// file: verif/rom_model.sv
/*
 * microcode store model: the word at addr points on to addr+1.
 * assumes the design reads it at next_microaddress_reg, same clock.
 */
`timescale 1ns/1ps
module rom_model
   import mseq_pkg::*;
(
   input  wire logic [UADDR_W-1:0] addr,
   output microword_s              word
);
   // length walks all four codes so one run shows every cycle type
   always_comb begin
      word.next_field           = addr + 9'h001;
      word.clk_len              = cyc_len_e'(addr[1:0]);
      word.microword_clock_halt = (addr == 9'h005);
      word.bus_wait             = (addr == 9'h008);
      word.reg_en               = 8'h01 << addr[2:0];
      word.ctl                  = addr[7:0];
   end
endmodule

// file: verif/mseq_clock_trace_tb.sv
/*
 * self-checking bench of the sequencer clock and trace block.
 * assumes rom_model feeds rom_word and registered outputs settle by negedge.
 */
`timescale 1ns/1ps
module mseq_clock_trace_tb;
   import mseq_pkg::*;
   logic              aclk = 1'h0, aresetn = 1'h0, force_valid = 1'h0;
   logic              halt_match_en = 1'h0, strobe_match_en = 1'h0, s_axi_bready = 1'h0;
   logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [3:0]        s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0]       s_axi_wdata = 32'h0;
   logic [2:0]        pn = 3'h0;
   logic [UADDR_W-1:0] console_switch_value = 9'h000, force_addr = 9'h000, next_microaddress_reg;
   logic [UADDR_W-1:0] past_microaddress_reg;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic              match, scope_strobe, clock_idle;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0]       s_axi_rdata, rd;
   logic [7:0]        reg_clk;
   microword_s        rom_word, microword;
   pulse_s            pulses;
   int                mismatches = 0, checks = 0, c1, c2, c3, cr0, cr3, cs, cbad;

   mseq_clock_trace dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rom_word,
      .branch_mod(9'h000), .force_valid, .force_addr, .async_restart(pn[0]), .maint_control(pn[1]),
      .clock_resume_req(pn[2]), .console_switch_value, .halt_match_en, .strobe_match_en, .microword,
      .next_microaddress_reg, .past_microaddress_reg, .match, .scope_strobe, .pulses, .reg_clk, .clock_idle);
   rom_model rom_u (.addr(next_microaddress_reg), .word(rom_word));

   initial begin
      forever #5 aclk = ~aclk;
   end
   // counts taken at negedge, where registered outputs have settled
   always @(negedge aclk) begin
      c1 += pulses.first_pulse;
      c2 += pulses.second_pulse;
      c3 += pulses.third_pulse;
      cr0 += reg_clk[0];
      cr3 += reg_clk[3];
      cs += scope_strobe;
      cbad += (scope_strobe && !pulses.last);
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // write: both channels offered together, each dropped at its own take
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      logic da, dw, db;
      da = 0;
      dw = 0;
      db = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      while (!db) begin
         @(negedge aclk);
         da = da | s_axi_awready;
         dw = dw | s_axi_wready;
         db = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (da) s_axi_awvalid <= 1'h0;
         if (dw) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
   endtask
   // read: arvalid held until the edge that takes it, data taken at the rvalid edge
   task automatic axr(input logic [3:0] a);
      logic dv, ta;
      dv = 0;
      ta = 0;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      while (!dv) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         dv = s_axi_rvalid;
         {rd, rsp} = {s_axi_rdata, s_axi_rresp};
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
   endtask
   // raise a pin, see whether the clock starts, then wait for it to stop
   task automatic go(input int i, input logic run);
      int n;
      {c1, c2, c3, cr0, cr3, cs, cbad} = '0;
      @(posedge aclk);
      pn[i] <= 1'h1;
      for (n = 0; n < 20 && clock_idle === 1'h1; n++) @(negedge aclk);
      chk(clock_idle, !run);
      @(posedge aclk);
      pn[i] <= 1'h0;
      for (n = 0; n < 400 && clock_idle !== 1'h1; n++) @(negedge aclk);
      chk(clock_idle, 32'h1);
      repeat (8) @(posedge aclk);
   endtask

   // words zero,0..4 run, word 5 halts; match functions disabled
   task automatic t_trace;
      console_switch_value <= 9'h003;
      go(0, 1);
      chk(past_microaddress_reg, 9'h005);
      chk(next_microaddress_reg, 9'h006);
      chk({c1[7:0], c2[7:0], c3[7:0]}, {8'h04, 8'h02, 8'h01});
      chk({cr0[7:0], cr3[7:0]}, {8'h01, 8'h02});
      chk(cs, 0);
      axr(OFS_ADDR);
      chk(rd, 32'h0006_0005);
      $display("t_trace done");
   endtask
   // halted word refuses resume; bus wait at 8; switch match stops at 12
   task automatic t_halt;
      go(2, 0);
      {console_switch_value, halt_match_en, strobe_match_en} <= {9'h00C, 2'h3};
      go(1, 1);
      chk(past_microaddress_reg, 9'h008);
      go(2, 1);
      chk(past_microaddress_reg, 9'h00C);
      // the halted word is loaded, so next has already moved past the switches
      chk(match, 1'h0);
      chk({cs[7:0], cbad[7:0]}, {8'h01, 8'h00});
      console_switch_value <= 9'h00D;
      repeat (8) @(posedge aclk);
      chk(match, 1'h1);
      axr(OFS_STATUS);
      chk(rd, 32'h3);
      $display("t_halt done");
   endtask
   // forced address replaces the sequential next address
   task automatic t_force;
      console_switch_value <= 9'h0FF;
      repeat (8) @(posedge aclk);
      chk(match, 1'h0);
      {force_addr, force_valid} <= {9'h005, 1'h1};
      go(0, 1);
      chk({past_microaddress_reg, next_microaddress_reg}, {9'h005, 9'h005});
      force_valid <= 1'h0;
      $display("t_force done");
   endtask
   // register resume refused on halted word, unmapped offset errors
   task automatic t_bus;
      axw(OFS_CTRL, 32'h1);
      chk(rsp, RESP_OKAY);
      repeat (10) @(posedge aclk);
      chk(clock_idle, 1'h1);
      axw(4'hC, 32'h1);
      chk(rsp, RESP_SLVERR);
      axr(4'hC);
      chk(rsp, RESP_SLVERR);
      chk(rd, 32'h0);
      $display("t_bus done");
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      t_trace();
      t_halt();
      t_force();
      t_bus();
      finish_test();
   end
   // hang guard, well beyond the few hundred cycles the tests need
   initial begin
      #300000;
      mismatches++;
      finish_test();
   end
endmodule
